/* File: logic/ufx_regs.sv */
// enhanced-feature register set of a dual-channel uart, with receive staging fifo
`timescale 1ns/1ps
`default_nettype none

// =========================================================
// staging fifo
module ufx_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic in_rdy;
    logic out_vld;
    logic [W-1:0] head;
  } ufx_fifo_st_t;
  localparam ufx_fifo_st_t FIFO_RST = '{in_rdy: 1'b1, default: '0};

  ufx_fifo_st_t s;
  ufx_fifo_st_t next_s;
  logic push;
  logic pop;

  always_comb begin
    next_s = s;
    push = in_valid && s.in_rdy;
    pop = s.out_vld && out_ready;
    if (push) begin
      next_s.mem[s.wp] = in_data;
      next_s.wp = (s.wp == AW'(D - 1)) ? '0 : s.wp + 1'b1;
    end
    if (pop) begin
      next_s.rp = (s.rp == AW'(D - 1)) ? '0 : s.rp + 1'b1;
    end
    if (push && !pop) begin
      next_s.cnt = s.cnt + 1'b1;
    end else if (pop && !push) begin
      next_s.cnt = s.cnt - 1'b1;
    end
    // flags registered so both handshake outputs come from flops
    next_s.in_rdy = next_s.cnt != (AW + 1)'(D);
    next_s.out_vld = next_s.cnt != '0;
    // head word kept in a flop so out_data leaves a register, same timing as the array read
    next_s.head = next_s.mem[next_s.rp];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= FIFO_RST;
    end else begin
      s <= next_s;
    end
  end

  assign in_ready = s.in_rdy;
  assign out_valid = s.out_vld;
  assign out_data = s.head;
endmodule : ufx_fifo

// =========================================================
// register set top
// Operation
// - feature bit 4 low blocks writes to irq enable 7:4, fifo setup 5:4, modem 7:5
// - feature bits 3:0 choose the software flow control combination
// - feature bit 5 flags a received second stop character, still stored
// - feature bit 6 raises rts at halt level, lowers it at resume level
// - feature bit 7 halts transmit while cts input is high
// - baud divisor is sixteen bits, high latch upper byte, low latch lower
// - level register low nibble halts, high nibble resumes, 0-60 in fours
// - level register writes need feature bit 4 and modem bit 6
// - trigger register holds tx spaces in 3:0, rx characters in 7:4, level/4
// - trigger register writes need feature bit 4 and modem bit 6
// - zero trigger nibble uses fifo setup level, nonzero overrides it
// - ready bits 0,1 show tx free spaces at least trigger; 3:2,7:6 zero
// - ready bits 4,5 show rx count above trigger or receive timeout
// - ready register read-only at 111 with a select low, modem bit 2, no loopback
// - feature register sits at 02 only while line setup holds BF
// - modem bit 6 swaps level and trigger registers into their addresses
// - modem bit 2 enables the ready register, else it is not selectable
// - irq enable bit 4 turns sleep mode on and off
module ufx_regs (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] channel_selects_n,
  input wire logic [2:0] addr,
  input wire logic iow_n,
  input wire logic ior_n,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  input wire logic [1:0] cts_n,
  input wire logic [1:0][6:0] rx_level,
  input wire logic [1:0][6:0] tx_free,
  input wire logic [1:0] rx_timeout,
  input wire logic [1:0] rx_in_valid,
  output logic [1:0] rx_in_ready,
  input wire logic [1:0][7:0] rx_in_data,
  output logic [1:0] rx_out_valid,
  input wire logic [1:0] rx_out_ready,
  output logic [1:0][7:0] rx_out_data,
  input wire logic [1:0] special_clr,
  output logic [1:0] rts_n,
  output logic [1:0] tx_allow,
  output logic [1:0] special_flag,
  output logic [1:0][15:0] baud_divisor,
  output logic [1:0][3:0] sw_flow_mode,
  output logic [1:0] sleep_en
);
  ufx_pkg::ufx_top_t s;
  ufx_pkg::ufx_top_t next_s;

  // =========================================================
  // address decode, shared by read and write paths
  function automatic ufx_pkg::ufx_reg_t ufx_decode(
    input logic [7:0] line,
    input logic [7:0] modem,
    input logic [7:0] feat,
    input logic [2:0] a,
    input logic rd
  );
    logic lvl_ok;
    lvl_ok = modem[ufx_pkg::MODEM_LVL_EN] && (rd || feat[ufx_pkg::FEAT_WEN]);
    ufx_decode = ufx_pkg::R_NONE;
    if (a == ufx_pkg::A_LINE) begin
      ufx_decode = ufx_pkg::R_LINE;
    end else if (line == ufx_pkg::LINE_FEAT_KEY) begin
      case (a)
        ufx_pkg::A_FEAT: ufx_decode = ufx_pkg::R_FEAT;
        ufx_pkg::A_RES1: ufx_decode = ufx_pkg::R_RES1;
        ufx_pkg::A_RES2: ufx_decode = ufx_pkg::R_RES2;
        ufx_pkg::A_STOP1: ufx_decode = ufx_pkg::R_STOP1;
        ufx_pkg::A_STOP2: ufx_decode = ufx_pkg::R_STOP2;
        default: ufx_decode = ufx_pkg::R_NONE;
      endcase
      // divisor key shadows only addresses 0 and 1, the rest keep their normal bank
    end else if (line == ufx_pkg::LINE_DIV_KEY && a == ufx_pkg::A_DIV_LO) begin
      ufx_decode = ufx_pkg::R_DIV_LO;
    end else if (line == ufx_pkg::LINE_DIV_KEY && a == ufx_pkg::A_DIV_HI) begin
      ufx_decode = ufx_pkg::R_DIV_HI;
    end else begin
      case (a)
        ufx_pkg::A_IRQEN: ufx_decode = ufx_pkg::R_IRQEN;
        ufx_pkg::A_FSET: ufx_decode = rd ? ufx_pkg::R_NONE : ufx_pkg::R_FSET;
        ufx_pkg::A_MODEM: ufx_decode = ufx_pkg::R_MODEM;
        ufx_pkg::A_LVLS: ufx_decode = lvl_ok ? ufx_pkg::R_LVLS : ufx_pkg::R_NONE;
        ufx_pkg::A_TRIG: begin
          // ready register wins the shared address on reads, never takes writes
          if (rd && modem[ufx_pkg::MODEM_RDY_EN] && !modem[ufx_pkg::MODEM_LOOP]) begin
            ufx_decode = ufx_pkg::R_RDY;
          end else if (lvl_ok) begin
            ufx_decode = ufx_pkg::R_TRIG;
          end
        end
        default: ufx_decode = ufx_pkg::R_NONE;
      endcase
    end
  endfunction : ufx_decode

  // a level nibble counts in steps of four bytes
  function automatic logic [6:0] ufx_lvl(
    input logic [3:0] nib
  );
    ufx_lvl = {1'b0, nib, 2'b00};
  endfunction : ufx_lvl

  // effective trigger, trigger register nibble counts in fours
  function automatic logic [6:0] ufx_trig(
    input logic [3:0] nib,
    input logic [1:0] fsel,
    input logic rx
  );
    if (nib != 4'h0) begin
      ufx_trig = ufx_lvl(nib);
    end else begin
      ufx_trig = rx ? ufx_pkg::RX_FSET_LVL[fsel] : ufx_pkg::TX_FSET_LVL[fsel];
    end
  endfunction : ufx_trig

  // =========================================================
  // receive staging fifos; full fifo stalls the shifter via rx_in_ready
  genvar g;
  generate
    for (g = 0; g < ufx_pkg::NCH; g++) begin : g_rxbuf
      ufx_fifo #(
        .W(ufx_pkg::DATA_W),
        .D(ufx_pkg::BUF_DEPTH)
      ) u_buf (
        .clk(clk),
        .rst(rst),
        .in_valid(rx_in_valid[g]),
        .in_ready(rx_in_ready[g]),
        .in_data(rx_in_data[g]),
        .out_valid(rx_out_valid[g]),
        .out_ready(rx_out_ready[g]),
        .out_data(rx_out_data[g])
      );
    end
  endgenerate

  // =========================================================
  // next state
  always_comb begin
    logic wr_stb;
    logic wen;
    logic rd_b;
    logic spec_hit;
    logic [7:0] rv;
    ufx_pkg::ufx_chan_t c;
    logic [6:0] halt_lvl;
    logic [6:0] resume_lvl;
    logic [6:0] tx_lvl;
    logic [6:0] rx_lvl;
    logic took;
    wr_stb = 1'b0;
    halt_lvl = 7'h00;
    resume_lvl = 7'h00;
    tx_lvl = 7'h00;
    rx_lvl = 7'h00;
    took = 1'b0;
    wen = 1'b0;
    rd_b = 1'b0;
    spec_hit = 1'b0;
    rv = 8'h00;
    c = ufx_pkg::CHAN_RST;
    next_s = s;
    next_s.iow_q = iow_n;
    // write taken once, on the falling edge of the write strobe
    wr_stb = !iow_n && s.iow_q;
    for (int i = 0; i < ufx_pkg::NCH; i++) begin
      c = s.ch[i];
      wen = c.feat[ufx_pkg::FEAT_WEN];
      // levels worked out once per channel for the flow and ready logic
      halt_lvl = ufx_lvl(c.lvls[3:0]);
      resume_lvl = ufx_lvl(c.lvls[7:4]);
      tx_lvl = ufx_trig(c.trig[3:0], c.fset[5:4], 1'b0);
      rx_lvl = ufx_trig(c.trig[7:4], c.fset[7:6], 1'b1);
      took = rx_in_valid[i] && rx_in_ready[i];
      if (wr_stb && !channel_selects_n[i]) begin
        case (ufx_decode(c.line, c.modem, c.feat, addr, 1'b0))
          ufx_pkg::R_DIV_LO: next_s.ch[i].div_lo = wdata;
          ufx_pkg::R_DIV_HI: next_s.ch[i].div_hi = wdata;
          ufx_pkg::R_FEAT: next_s.ch[i].feat = wdata;
          ufx_pkg::R_RES1: next_s.ch[i].res1 = wdata;
          ufx_pkg::R_RES2: next_s.ch[i].res2 = wdata;
          ufx_pkg::R_STOP1: next_s.ch[i].stop1 = wdata;
          ufx_pkg::R_STOP2: next_s.ch[i].stop2 = wdata;
          // locked fields keep their old bits instead of taking the write
          ufx_pkg::R_IRQEN: next_s.ch[i].irqen = wen ? wdata : {c.irqen[7:4], wdata[3:0]};
          ufx_pkg::R_FSET: next_s.ch[i].fset = wen ? wdata : {wdata[7:6], c.fset[5:4], wdata[3:0]};
          ufx_pkg::R_MODEM: next_s.ch[i].modem = wen ? wdata : {c.modem[7:5], wdata[4:0]};
          ufx_pkg::R_LINE: next_s.ch[i].line = wdata;
          ufx_pkg::R_LVLS: next_s.ch[i].lvls = wdata;
          ufx_pkg::R_TRIG: next_s.ch[i].trig = wdata;
          default: next_s.ch[i].line = next_s.ch[i].line;
        endcase
      end
      // auto rts: hysteresis between halt and resume levels
      if (c.feat[ufx_pkg::FEAT_ARTS]) begin
        if (rx_level[i] >= halt_lvl) begin
          next_s.ch[i].rts_n = 1'b1;
        end else if (rx_level[i] <= resume_lvl) begin
          next_s.ch[i].rts_n = 1'b0;
        end
      end else begin
        next_s.ch[i].rts_n = !c.modem[ufx_pkg::MODEM_RTS];
      end
      // only the start of a new character is gated, one in flight completes
      next_s.ch[i].tx_allow = !(c.feat[ufx_pkg::FEAT_ACTS] && cts_n[i]);
      // stored regardless of the match; set beats a same-cycle clear
      spec_hit = took && c.feat[ufx_pkg::FEAT_SPEC] && rx_in_data[i] == c.stop2;
      next_s.ch[i].spec_flag = spec_hit || (c.spec_flag && !special_clr[i]);
      // ready bits lag their inputs by one cycle, like the other status here
      next_s.ch[i].tx_rdy = tx_free[i] >= tx_lvl;
      next_s.ch[i].rx_rdy = rx_level[i] > rx_lvl || rx_timeout[i];
    end
    // read path: channel a answers when both selects are low
    rd_b = channel_selects_n[0];
    c = rd_b ? s.ch[1] : s.ch[0];
    if (!ior_n && channel_selects_n != 2'b11) begin
      case (ufx_decode(c.line, c.modem, c.feat, addr, 1'b1))
        ufx_pkg::R_DIV_LO: rv = c.div_lo;
        ufx_pkg::R_DIV_HI: rv = c.div_hi;
        ufx_pkg::R_FEAT: rv = c.feat;
        ufx_pkg::R_RES1: rv = c.res1;
        ufx_pkg::R_RES2: rv = c.res2;
        ufx_pkg::R_STOP1: rv = c.stop1;
        ufx_pkg::R_STOP2: rv = c.stop2;
        ufx_pkg::R_IRQEN: rv = c.irqen;
        ufx_pkg::R_LINE: rv = c.line;
        ufx_pkg::R_MODEM: rv = c.modem;
        ufx_pkg::R_LVLS: rv = c.lvls;
        ufx_pkg::R_TRIG: rv = c.trig;
        ufx_pkg::R_RDY: rv = {2'b00, s.ch[1].rx_rdy, s.ch[0].rx_rdy,
                              2'b00, s.ch[1].tx_rdy, s.ch[0].tx_rdy};
        default: rv = 8'h00;
      endcase
    end
    next_s.rdata = rv;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= ufx_pkg::TOP_RST;
    end else begin
      s <= next_s;
    end
  end

  // =========================================================
  // outputs
  assign rdata = s.rdata;
  generate
    for (g = 0; g < ufx_pkg::NCH; g++) begin : g_out
      assign rts_n[g] = s.ch[g].rts_n;
      assign tx_allow[g] = s.ch[g].tx_allow;
      assign special_flag[g] = s.ch[g].spec_flag;
      // latch writes after sleep enable are not guarded here
      assign baud_divisor[g] = {s.ch[g].div_hi, s.ch[g].div_lo};
      assign sw_flow_mode[g] = s.ch[g].feat[3:0];
      assign sleep_en[g] = s.ch[g].irqen[ufx_pkg::IRQEN_SLEEP];
    end
  endgenerate
endmodule : ufx_regs

`default_nettype wire

/* File: logic/ufx_pkg.sv */
// constants, register decode ids and state types of the enhanced uart register set
package ufx_pkg;
  // =========================================================
  // addresses on the 3-bit host bus
  localparam logic [2:0] A_DIV_LO = 3'h0;
  localparam logic [2:0] A_DIV_HI = 3'h1;
  localparam logic [2:0] A_IRQEN = 3'h1;
  localparam logic [2:0] A_FEAT = 3'h2;
  localparam logic [2:0] A_FSET = 3'h2;
  localparam logic [2:0] A_LINE = 3'h3;
  localparam logic [2:0] A_MODEM = 3'h4;
  localparam logic [2:0] A_RES1 = 3'h4;
  localparam logic [2:0] A_RES2 = 3'h5;
  localparam logic [2:0] A_STOP1 = 3'h6;
  localparam logic [2:0] A_STOP2 = 3'h7;
  localparam logic [2:0] A_LVLS = 3'h6;
  localparam logic [2:0] A_TRIG = 3'h7;
  localparam logic [2:0] A_RDY = 3'h7;
  // =========================================================
  // line setup keys that open the divisor and feature banks
  localparam logic [7:0] LINE_DIV_KEY = 8'h80;
  localparam logic [7:0] LINE_FEAT_KEY = 8'hBF;
  // =========================================================
  // bit positions
  localparam int FEAT_WEN = 4;
  localparam int FEAT_SPEC = 5;
  localparam int FEAT_ARTS = 6;
  localparam int FEAT_ACTS = 7;
  localparam int MODEM_RTS = 1;
  localparam int MODEM_RDY_EN = 2;
  localparam int MODEM_LOOP = 4;
  localparam int MODEM_LVL_EN = 6;
  localparam int IRQEN_SLEEP = 4;
  // =========================================================
  // fifo setup trigger tables, indexed by the two-bit field
  localparam logic [3:0][6:0] RX_FSET_LVL = {7'h3C, 7'h38, 7'h10, 7'h08};
  localparam logic [3:0][6:0] TX_FSET_LVL = {7'h38, 7'h20, 7'h10, 7'h08};
  // =========================================================
  // fifo shape and widths
  localparam int DATA_W = 8;
  localparam int BUF_DEPTH = 8;
  localparam int LVL_W = 7;
  localparam int NCH = 2;
  // =========================================================
  typedef enum logic [3:0] {
    R_NONE, R_DIV_LO, R_DIV_HI, R_FEAT, R_RES1, R_RES2, R_STOP1, R_STOP2,
    R_IRQEN, R_FSET, R_LINE, R_MODEM, R_LVLS, R_TRIG, R_RDY
  } ufx_reg_t;

  typedef struct packed {
    logic [7:0] div_lo;
    logic [7:0] div_hi;
    logic [7:0] feat;
    logic [7:0] res1;
    logic [7:0] res2;
    logic [7:0] stop1;
    logic [7:0] stop2;
    logic [7:0] irqen;
    logic [7:0] fset;
    logic [7:0] line;
    logic [7:0] modem;
    logic [7:0] lvls;
    logic [7:0] trig;
    logic rts_n;
    logic tx_allow;
    logic spec_flag;
    logic tx_rdy;
    logic rx_rdy;
  } ufx_chan_t;

  typedef struct packed {
    ufx_chan_t [NCH-1:0] ch;
    logic iow_q;
    logic [7:0] rdata;
  } ufx_top_t;

  localparam ufx_chan_t CHAN_RST = '{rts_n: 1'b1, tx_allow: 1'b1, default: '0};
  localparam ufx_top_t TOP_RST = '{ch: {CHAN_RST, CHAN_RST}, iow_q: 1'b1, rdata: 8'h00};
endpackage : ufx_pkg

/* File: test/ufx_regs_props.sv */
// concurrent checks on the ports of the enhanced uart register set
`timescale 1ns/1ps
`default_nettype none
module ufx_regs_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] channel_selects_n,
  input wire logic iow_n,
  input wire logic ior_n,
  input wire logic [7:0] rdata,
  input wire logic [1:0] cts_n,
  input wire logic [1:0] rx_in_valid,
  input wire logic [1:0] rx_in_ready,
  input wire logic [1:0] rx_out_valid,
  input wire logic [1:0] special_clr,
  input wire logic [1:0] tx_allow,
  input wire logic [1:0] special_flag,
  input wire logic [1:0][15:0] baud_divisor,
  input wire logic [1:0][3:0] sw_flow_mode,
  input wire logic [1:0] sleep_en
);
  // =========================================================
  // one domain, so clock and reset are given once
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // =========================================================
  // bus side
  read_idle_zero_a: assert property ((ior_n || &channel_selects_n) |=> rdata == 8'h00)
    else $error("read data not zero while idle");
  divisor_by_write_a: assert property (!$stable(baud_divisor) |-> !$past(iow_n) && $past(iow_n, 2))
    else $error("divisor changed without a write");
  flow_mode_write_a: assert property (!$stable(sw_flow_mode[0]) |-> $past(iow_n, 2) && !$past(channel_selects_n[0]))
    else $error("flow mode changed without a write");
  sleep_on_write_a: assert property ($rose(sleep_en[0]) |-> !$past(iow_n) && !$past(channel_selects_n[0]))
    else $error("sleep enabled without a write");
  // =========================================================
  // flow and receive side
  cts_low_sends_a: assert property (!cts_n[0] |=> tx_allow[0])
    else $error("transmit held while cts low");
  special_cause_a: assert property ($rose(special_flag[0]) |-> $past(rx_in_valid[0]) && $past(rx_in_ready[0]))
    else $error("special flag without a received char");
  special_clear_a: assert property (special_clr[0] && !(rx_in_valid[0] && rx_in_ready[0]) |=> !special_flag[0])
    else $error("special flag not cleared");
  char_stored_a: assert property (rx_in_valid[0] && rx_in_ready[0] |=> rx_out_valid[0])
    else $error("accepted char not stored");
endmodule : ufx_regs_props
`default_nettype wire

/* File: test/ufx_host.sv */
// host processor model on the 8-bit parallel register bus
`timescale 1ns/1ps
`default_nettype none
module ufx_host (
  input wire logic clk,
  output logic [1:0] channel_selects_n,
  output logic [2:0] addr,
  output logic iow_n,
  output logic ior_n,
  output logic [7:0] wdata,
  input wire logic [7:0] rdata
);
  initial begin
    channel_selects_n = 2'h3;
    addr = 3'h0;
    iow_n = 1'b1;
    ior_n = 1'b1;
    wdata = 8'h00;
  end
  // =========================================================
  // write strobe returns high a full cycle, so each write is a fresh falling edge
  task automatic wr(input logic [1:0] cs, input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    channel_selects_n <= cs;
    addr <= a;
    wdata <= d;
    iow_n <= 1'b0;
    @(posedge clk);
    iow_n <= 1'b1;
    channel_selects_n <= 2'h3;
    wdata <= ~d;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [1:0] cs, input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    channel_selects_n <= cs;
    addr <= a;
    ior_n <= 1'b0;
    @(posedge clk);
    @(posedge clk);
    d = rdata;
    ior_n <= 1'b1;
    channel_selects_n <= 2'h3;
  endtask : rd
endmodule : ufx_host
`default_nettype wire

/* File: test/ufx_regs_tb.sv */
// self-checking bench of the enhanced uart register set
`timescale 1ns/1ps
`default_nettype none
module ufx_regs_tb;
  typedef struct packed {
    logic [7:0] line;
    logic [2:0] a;
    logic [7:0] d;
    logic [7:0] exp;
  } ufx_row_t;
  // levels before auto flow, divisor before sleep
  localparam ufx_row_t ROWS [14] = '{'{8'hBF, 3'h4, 8'h11, 8'h11}, '{8'hBF, 3'h5, 8'h13, 8'h13},
    '{8'hBF, 3'h6, 8'h22, 8'h22}, '{8'hBF, 3'h7, 8'h93, 8'h93}, '{8'hBF, 3'h2, 8'h10, 8'h10},
    '{8'h80, 3'h0, 8'h34, 8'h34}, '{8'h80, 3'h1, 8'h12, 8'h12}, '{8'h00, 3'h4, 8'h40, 8'h40},
    '{8'h00, 3'h6, 8'h28, 8'h28}, '{8'h00, 3'h7, 8'h31, 8'h31}, '{8'h00, 3'h4, 8'h44, 8'h44},
    '{8'hBF, 3'h2, 8'hF3, 8'hF3}, '{8'h00, 3'h1, 8'h10, 8'h10}, '{8'h00, 3'h5, 8'h55, 8'h00}};
  localparam logic [7:0] WD [8] = '{8'h41, 8'h93, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h47};
  localparam logic [6:0] LV [5] = '{7'h08, 7'h1F, 7'h20, 7'h09, 7'h08};
  localparam logic EX [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] channel_selects_n, rx_in_ready, rx_out_valid, rts_n, tx_allow, special_flag, sleep_en;
  logic [2:0] addr;
  logic iow_n, ior_n;
  logic [7:0] wdata, rdata, rd_v;
  logic [1:0] cts_n = 2'h0, rx_timeout = 2'h0, rx_in_valid = 2'h0, rx_out_ready = 2'h0, special_clr = 2'h0;
  logic [1:0][6:0] rx_level = '0, tx_free = '0;
  logic [1:0][7:0] rx_in_data = '0, rx_out_data;
  logic [1:0][15:0] baud_divisor;
  logic [1:0][3:0] sw_flow_mode;
  int num_errors = 0;
  int n_checks = 0;
  always #2 clk = ~clk;
  ufx_host i_host (.clk, .channel_selects_n, .addr, .iow_n, .ior_n, .wdata, .rdata);
  ufx_regs i_dut (.clk, .rst, .channel_selects_n, .addr, .iow_n, .ior_n, .wdata, .rdata, .cts_n, .rx_level,
    .tx_free, .rx_timeout, .rx_in_valid, .rx_in_ready, .rx_in_data, .rx_out_valid, .rx_out_ready,
    .rx_out_data, .special_clr, .rts_n, .tx_allow, .special_flag, .baud_divisor, .sw_flow_mode, .sleep_en);
  // =========================================================
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  // =========================================================
  initial begin
    #40000;
    num_errors++;
    give_verdict();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    foreach (ROWS[i]) begin
      i_host.wr(2'h2, ufx_pkg::A_LINE, ROWS[i].line);
      i_host.wr(2'h2, ROWS[i].a, ROWS[i].d);
      i_host.rd(2'h2, ROWS[i].a, rd_v);
      chk(rd_v, ROWS[i].exp);
    end
    chk(baud_divisor, 32'h00001234);
    chk(sw_flow_mode, 8'h03);
    rx_level <= {7'h09, 7'h0D};
    tx_free <= {7'h07, 7'h04};
    i_host.rd(2'h2, ufx_pkg::A_RDY, rd_v);
    chk(rd_v, 8'h31);
    rx_level <= {7'h00, 7'h0C};
    tx_free <= {7'h08, 7'h03};
    rx_timeout <= 2'h2;
    i_host.rd(2'h2, ufx_pkg::A_RDY, rd_v);
    chk(rd_v, 8'h22);
    // loopback hides the ready register, trigger register answers instead
    i_host.wr(2'h2, ufx_pkg::A_MODEM, 8'h54);
    i_host.rd(2'h2, ufx_pkg::A_RDY, rd_v);
    chk(rd_v, 8'h31);
    i_host.wr(2'h2, ufx_pkg::A_MODEM, 8'h44);
    foreach (LV[i]) begin
      @(posedge clk) rx_level <= {7'h00, LV[i]};
      repeat (2) @(posedge clk);
      #1 chk(rts_n[0], EX[i]);
    end
    @(posedge clk) cts_n <= 2'h3;
    repeat (2) @(posedge clk);
    #1 chk(tx_allow, 2'h2);
    @(posedge clk) cts_n <= 2'h0;
    repeat (2) @(posedge clk);
    #1 chk(tx_allow, 2'h3);
    // channel b never unlocked its enhanced bits
    i_host.wr(2'h1, ufx_pkg::A_MODEM, 8'hE6);
    i_host.rd(2'h1, ufx_pkg::A_MODEM, rd_v);
    chk({rd_v, rts_n[1]}, 9'h00C);
    i_host.wr(2'h1, ufx_pkg::A_IRQEN, 8'hF0);
    i_host.rd(2'h1, ufx_pkg::A_IRQEN, rd_v);
    chk({rd_v, sleep_en}, 10'h001);
    // fill the staging fifo while the far side stalls
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      rx_in_valid <= 2'h1;
      rx_in_data <= {8'h00, WD[i]};
    end
    @(posedge clk);
    rx_in_valid <= 2'h0;
    @(posedge clk);
    #1 chk({rx_in_ready, special_flag}, 4'h9);
    @(posedge clk) rx_out_ready <= 2'h1;
    for (int i = 0; i < 8; i++) begin
      @(negedge clk) chk({rx_out_valid[0], rx_out_data[0]}, {1'b1, WD[i]});
      @(posedge clk);
    end
    rx_out_ready <= 2'h0;
    @(posedge clk) special_clr <= 2'h1;
    @(posedge clk) special_clr <= 2'h0;
    @(posedge clk);
    #1 chk({rx_out_valid, special_flag}, 4'h0);
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk({rts_n, tx_allow, special_flag, sleep_en, rx_in_ready, rx_out_valid}, 12'hF0C);
    chk({baud_divisor, sw_flow_mode}, 40'h0);
    // second release: registers start clean, a write to both channels lands
    @(posedge clk) rst <= 1'b0;
    i_host.rd(2'h2, ufx_pkg::A_LINE, rd_v);
    chk(rd_v, 8'h00);
    i_host.wr(2'h0, ufx_pkg::A_LINE, ufx_pkg::LINE_DIV_KEY);
    i_host.wr(2'h0, ufx_pkg::A_DIV_LO, 8'h5A);
    #1 chk(baud_divisor, 32'h005A005A);
    give_verdict();
  end
endmodule : ufx_regs_tb
bind ufx_regs ufx_regs_props i_props (.clk, .rst, .channel_selects_n, .iow_n, .ior_n, .rdata, .cts_n,
  .rx_in_valid, .rx_in_ready, .rx_out_valid, .special_clr, .tx_allow, .special_flag, .baud_divisor,
  .sw_flow_mode, .sleep_en);
`default_nettype wire
